// >>> design/iqm_pkg.sv
/*
 * Constants for the I/O monitoring and cache-allocation register bank.
 * Assumes a host memory port with 64-bit data, byte enables and a
 * one-cycle read answer; addresses are byte offsets into the bank.
 */
package iqm_pkg;
	// ********************************
	// Geometry
	// ********************************
	localparam int unsigned BLOCK_BYTES = 4096;
	localparam int unsigned REG_BYTES = 8;
	localparam int unsigned ADDR_W = 16;
	localparam logic [3:0] INDEX_VERSION = 4'h1;
	// ********************************
	// Counter register fields
	// ********************************
	localparam int unsigned UNAVAIL_BIT = 63;
	localparam int unsigned OVERFLOW_BIT = 62;
	localparam int unsigned COUNT_W = 62;
	localparam logic [61:0] COUNT_RESET = 62'h0;
	// ********************************
	// Mask register fields
	// ********************************
	localparam int unsigned MASK_LSB = 32;
	localparam int unsigned MASK_W = 32;
	// ********************************
	// Layout defaults
	// ********************************
	localparam logic [15:0] CNT_OFFSET = 16'h0000;
	localparam logic [15:0] MASK_OFFSET = 16'h0800;
	localparam logic [31:0] MASK_RESET = 32'hFFFFFFFF;
endpackage : iqm_pkg

// >>> design/iqm_counter.sv
/*
 * One miss bandwidth counter with overflow and unavailable flags.
 * Assumes the increment pulse and read-clear pulse are synchronous.
 */
`timescale 1ns/1ps
module iqm_counter (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic monitored,
	input wire logic inc,
	input wire logic rd_clr,
	output logic [63:0] value
);
	typedef struct packed {
		logic [61:0] cnt;
		logic ovf;
	} iqm_cnt_state_t;
	iqm_cnt_state_t st_ff;
	iqm_cnt_state_t nxt_st;

	// Count wraps to zero and flags overflow; a wrap beats a read clear
	always_comb begin
		nxt_st = st_ff;
		if (rd_clr) begin
			nxt_st.ovf = 1'b0;
		end
		if (inc && monitored) begin
			nxt_st.cnt = st_ff.cnt + 62'h1;
			if (&st_ff.cnt) begin
				nxt_st.ovf = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '{cnt: iqm_pkg::COUNT_RESET, ovf: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Unavailable shows while the tag is not monitored
	assign value = {~monitored, st_ff.ovf, st_ff.cnt};

	chk_wrap_sets_ovf: assert property (@(posedge clock) disable iff (!rst_n)
		inc && monitored && (&st_ff.cnt) |=> st_ff.ovf && st_ff.cnt == 62'h0)
		else $error("wrap did not set overflow");
	chk_read_clears: assert property (@(posedge clock) disable iff (!rst_n)
		rd_clr && !(inc && monitored && (&st_ff.cnt)) |=> !st_ff.ovf)
		else $error("read did not clear overflow");
	chk_count_step: assert property (@(posedge clock) disable iff (!rst_n)
		inc && monitored |=> st_ff.cnt == $past(st_ff.cnt) + 62'h1)
		else $error("count did not step");
	chk_idle_hold: assert property (@(posedge clock) disable iff (!rst_n)
		!(inc && monitored) |=> st_ff.cnt == $past(st_ff.cnt))
		else $error("count moved without event");
endmodule : iqm_counter

// >>> design/iqm_regs.sv
/*
 * Register bank: per-tag miss counters and per-class way masks.
 * Assumes a simple memory port: one request per cycle, 64-bit data,
 * byte enables, read data valid one cycle after the request.
 */
`timescale 1ns/1ps
module iqm_regs #(
	parameter int unsigned NUM_TAGS = 8,
	parameter int unsigned CLUMP = 4,
	parameter int unsigned NUM_BLOCKS = 2,
	parameter int unsigned NUM_CLASSES = 4,
	parameter int unsigned NUM_WAYS = 12
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic req,
	input wire logic wr,
	input wire logic [iqm_pkg::ADDR_W-1:0] addr,
	input wire logic [63:0] wdata,
	input wire logic [7:0] be,
	output logic [63:0] rdata,
	output logic rvalid,
	output logic [3:0] index_version,
	input wire logic [NUM_TAGS-1:0] tag_monitored,
	input wire logic [NUM_TAGS-1:0] miss_inc,
	output logic [NUM_CLASSES*iqm_pkg::MASK_W-1:0] class_mask
);
	localparam int unsigned BW = $clog2(iqm_pkg::BLOCK_BYTES);
	localparam int unsigned RW = $clog2(iqm_pkg::REG_BYTES);
	localparam logic [63:0] WAY_ONES = (64'h1 << NUM_WAYS) - 64'h1;
	localparam logic [iqm_pkg::MASK_W-1:0] WAY_LIMIT =
		WAY_ONES[iqm_pkg::MASK_W-1:0];

	typedef struct packed {
		logic [NUM_CLASSES-1:0][iqm_pkg::MASK_W-1:0] mask;
		logic [63:0] rdata;
		logic rvalid;
	} iqm_state_t;
	iqm_state_t st_ff;
	iqm_state_t nxt_st;

	logic [NUM_TAGS-1:0][63:0] cnt_val;
	logic [NUM_TAGS-1:0] cnt_hit;
	logic [NUM_CLASSES-1:0] mask_hit;
	logic [NUM_TAGS-1:0] rd_clr;

	// Fixed version 1 layout; the address map below assumes it
	assign index_version = iqm_pkg::INDEX_VERSION;

	// ********************************
	// Address decode
	// ********************************
	// Every tag lands in its clump's block, inside the bank
	// Region-id registers are not decoded at all
	genvar g;
	generate
		for (g = 0; g < NUM_TAGS; g++) begin : g_tag
			localparam int unsigned A = (g / CLUMP) * iqm_pkg::BLOCK_BYTES
				+ int'(iqm_pkg::CNT_OFFSET)
				+ (g % CLUMP) * iqm_pkg::REG_BYTES;
			localparam logic [iqm_pkg::ADDR_W-1:0] A_HIT =
				A[iqm_pkg::ADDR_W-1:0];
			assign cnt_hit[g] = req && (addr[iqm_pkg::ADDR_W-1:RW] ==
				A_HIT[iqm_pkg::ADDR_W-1:RW]);
			assign rd_clr[g] = cnt_hit[g] && !wr;
			iqm_counter iqm_counter_inst (
				.clock(clock),
				.rst_n(rst_n),
				.monitored(tag_monitored[g]),
				.inc(miss_inc[g]),
				.rd_clr(rd_clr[g]),
				.value(cnt_val[g])
			);
		end
		// Any block's copy hits the same class; one mask bank shared by all blocks
		// Classes zero up to the last one each get a register
		for (g = 0; g < NUM_CLASSES; g++) begin : g_cls
			localparam int unsigned M = int'(iqm_pkg::MASK_OFFSET)
				+ g * iqm_pkg::REG_BYTES;
			localparam logic [iqm_pkg::ADDR_W-1:0] M_HIT =
				M[iqm_pkg::ADDR_W-1:0];
			assign mask_hit[g] = req &&
				(addr[BW-1:RW] == M_HIT[BW-1:RW]) &&
				(int'(addr[iqm_pkg::ADDR_W-1:BW]) < NUM_BLOCKS);
			assign class_mask[g*iqm_pkg::MASK_W +: iqm_pkg::MASK_W] =
				st_ff.mask[g];
		end
	endgenerate

	// ********************************
	// Access handling
	// ********************************
	// Replicas share storage, so copies never disagree on read back
	always_comb begin
		logic [31:0] nm;
		nm = 32'h0;
		nxt_st = st_ff;
		nxt_st.rvalid = req && !wr;
		nxt_st.rdata = 64'h0; // Unmapped and reserved reads give zero
		for (int c = 0; c < NUM_CLASSES; c++) begin
			if (mask_hit[c]) begin
				if (wr) begin
					nm = st_ff.mask[c];
					for (int b = 0; b < 4; b++) begin
						if (be[4+b]) begin
							nm[8*b +: 8] = wdata[32+8*b +: 8];
						end
					end
					// Bits past the way count make the value too large
					if ((nm & ~WAY_LIMIT) == 32'h0) begin
						nxt_st.mask[c] = nm;
					end
				end else begin
					nxt_st.rdata = {st_ff.mask[c], 32'h0};
				end
			end
		end
		for (int t = 0; t < NUM_TAGS; t++) begin
			if (cnt_hit[t] && !wr) begin
				nxt_st.rdata = cnt_val[t];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '{mask: {NUM_CLASSES{iqm_pkg::MASK_RESET}},
				rdata: 64'h0, rvalid: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rdata = st_ff.rdata;
	assign rvalid = st_ff.rvalid;

	// ********************************
	// Checks
	// ********************************
	chk_cnt_in_bank: assert property (@(posedge clock) disable iff (!rst_n)
		|cnt_hit |-> int'(addr) < NUM_BLOCKS * iqm_pkg::BLOCK_BYTES)
		else $error("counter decoded past bank end");
	chk_rd_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
		req && !wr |=> rvalid)
		else $error("read answer missing");
	chk_low_half_zero: assert property (@(posedge clock) disable iff (!rst_n)
		|mask_hit && !wr |=> rdata[31:0] == 32'h0)
		else $error("mask low half not zero");
	chk_write_ignored: assert property (@(posedge clock) disable iff (!rst_n)
		req && wr && !(|mask_hit) |=> st_ff.mask == $past(st_ff.mask))
		else $error("stray write changed a mask");
	chk_mask_in_ways: assert property (@(posedge clock) disable iff (!rst_n)
		rvalid && $past(|mask_hit) |-> (rdata[63:32] & ~WAY_LIMIT) == 0
		|| iqm_pkg::MASK_RESET == rdata[63:32])
		else $error("mask beyond way count");
	chk_write_no_ans: assert property (@(posedge clock) disable iff (!rst_n)
		req && wr |=> !rvalid)
		else $error("write produced answer");
endmodule : iqm_regs

// >>> sim/testbench.sv
/*
 * Self-checking bench for the I/O monitor and way-mask register bank.
 * Assumes the default layout: counters from offset 0, masks at 0x800,
 * four tags per clump, two blocks, and a one-cycle read answer.
 */
`timescale 1ns/1ps
module testbench;
	logic clock;
	logic rst_n;
	logic req;
	logic wr;
	logic rvalid;
	logic [iqm_pkg::ADDR_W-1:0] addr;
	logic [63:0] wdata;
	logic [63:0] rdata;
	logic [63:0] seen;
	logic [7:0] be;
	logic [3:0] index_version;
	logic [7:0] tag_monitored;
	logic [7:0] miss_inc;
	logic [127:0] class_mask;
	int err_count;
	int comparisons;

	iqm_regs iqm_regs_inst (
		.clock(clock),
		.rst_n(rst_n),
		.req(req),
		.wr(wr),
		.addr(addr),
		.wdata(wdata),
		.be(be),
		.rdata(rdata),
		.rvalid(rvalid),
		.index_version(index_version),
		.tag_monitored(tag_monitored),
		.miss_inc(miss_inc),
		.class_mask(class_mask)
	);

	// ********************************
	// Clock
	// ********************************
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// ********************************
	// Tasks
	// ********************************
	// Counts every compare so an empty run cannot pass
	task check(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : check

	task end_of_test;
		if (err_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test

	// One access; a read waits a bounded time for the answer pulse
	// Plain single loads and stores only, never locked
	task access(input logic w, input logic [15:0] a, input logic [63:0] d,
			input logic [7:0] b);
		int n;
		@(posedge clock);
		#1;
		req = 1'b1;
		wr = w;
		addr = a;
		wdata = d;
		be = b;
		@(posedge clock);
		#1;
		req = 1'b0;
		n = 0;
		while (!w && rvalid !== 1'b1 && n < 4) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n == 4) begin
			err_count++;
			$display("wrong value at %0t: read answer timed out", $time);
			end_of_test;
		end
		seen = rdata;
	endtask : access

	task rd(input logic [15:0] a, input logic [63:0] exp);
		access(1'b0, a, 64'h0, 8'hFF);
		check(seen, exp);
	endtask : rd

	// ********************************
	// Main sequence
	// ********************************
	// Tag 5 is left unmonitored; tags 3, 6 and 7 see three misses each
	initial begin
		rst_n = 1'b0;
		req = 1'b0;
		wr = 1'b0;
		addr = '0;
		wdata = 64'h0;
		be = 8'h00;
		tag_monitored = 8'hDF;
		miss_inc = 8'h00;
		err_count = 0;
		comparisons = 0;
		repeat (3) @(posedge clock);
		#1 rst_n = 1'b1;
		check({60'h0, index_version}, 64'h1);
		rd(16'h0000, 64'h0);
		rd(16'h1008, 64'h8000000000000000);
		@(posedge clock);
		#1 miss_inc = 8'hC8;
		repeat (3) @(posedge clock);
		#1 miss_inc = 8'h00;
		rd(16'h0018, 64'h3);
		rd(16'h1010, 64'h3);
		rd(16'h1018, 64'h3);
		rd(16'h1000, 64'h0);
		// Counters are read-only: a write must not disturb the count
		access(1'b1, 16'h1010, 64'h55, 8'hFF);
		rd(16'h1010, 64'h3);
		rd(16'h0808, 64'hFFFFFFFF00000000);
		access(1'b1, 16'h1810, 64'h00000ABCFFFFFFFF, 8'hFF);
		access(1'b1, 16'h0810, 64'h00000ABC00000000, 8'hF0);
		rd(16'h0810, 64'h00000ABC00000000);
		check({32'h0, class_mask[95:64]}, 64'hABC);
		// Bit 12 lies past the way count, so the whole write is dropped
		access(1'b1, 16'h0810, 64'h00001ABC00000000, 8'hF0);
		rd(16'h1810, 64'h00000ABC00000000);
		access(1'b1, 16'h0818, 64'h00000FFF00000000, 8'hF0);
		rd(16'h1818, 64'h00000FFF00000000);
		rd(16'h0820, 64'h0);
		rd(16'h2000, 64'h0);
		rd(16'h2808, 64'h0);
		// Tag 5 turns monitored: valid data, still no counts
		tag_monitored = 8'hFF;
		rd(16'h1008, 64'h0);
		// Reset mid-run: counts return to zero, masks to reset value
		@(posedge clock);
		#1 rst_n = 1'b0;
		@(posedge clock);
		#1 rst_n = 1'b1;
		rd(16'h0018, 64'h0);
		rd(16'h1818, {iqm_pkg::MASK_RESET, 32'h0});
		end_of_test;
	end
endmodule : testbench
